// ### pkg/trcp_defines.svh
// Constants of the tape read and check path: step numbers, masks and timing.
// Assumes a single 200 MHz clock; included by the design modules.
`ifndef TRCP_DEFINES_SVH
`define TRCP_DEFINES_SVH
`define TRCP_CLK_NS 5
`define TRCP_US_NS 1000
`define TRCP_US_CYC (`TRCP_US_NS / `TRCP_CLK_NS)
`define TRCP_GATE_MS 4
`define TRCP_GATE_CYC (`TRCP_GATE_MS * 1000000 / `TRCP_CLK_NS)
`define TRCP_STEP_XFER 4'h8
`define TRCP_STEP_CLR 4'h9
`define TRCP_STEP_END_RD 4'ha
`define TRCP_STEP_END_CHK 4'hc
`define TRCP_STEP_TMR_LO 4'h2
`define TRCP_STEP_TMR_HI 4'h3
`define TRCP_MARK_NINE 9'h0c8
`define TRCP_CARE_NINE 9'h1ff
`define TRCP_MARK_SEVEN 9'h00f
`define TRCP_CARE_SEVEN 9'h13f
`define TRCP_CHAR_US 8'h10
`define TRCP_EOB_MARK_US ((`TRCP_CHAR_US * 32'h17) / 32'h0a)
`endif

// ### pkg/trcp_pkg.sv
// Types shared by the read clock and the read check path.
// Assumes trcp_defines.svh is on the include path.
package trcp_pkg;
  // State of the read clock: divider, first-bit latch and step counter.
  typedef struct packed {
    logic [7:0] div;
    logic first_bit;
    logic [3:0] step;
    logic adv;
  } trcp_rclk_s;
  // State of the read check path.
  typedef struct packed {
    logic [8:0] trk_s1;
    logic [8:0] trk_s2;
    logic [19:0] gate_cnt;
    logic gate_run;
    logic data_gate;
    logic [8:0] rr;
    logic [8:0] toggles;
    logic [8:0] wtrig;
    logic [8:0] wbits;
    logic [7:0] chan_byte;
    logic chan_par;
    logic chan_strobe;
    logic held;
    logic rr_vpar_err;
    logic first_char;
    logic bytes_seen;
    logic tm_latch;
    logic p2;
    logic [7:0] eob_us;
    logic read_disc;
    logic lrc_err;
    logic data_check;
    logic unit_check;
    logic unit_exc;
    logic file_end;
    logic sense_strobe;
  } trcp_st_s;
endpackage

// ### pkg/trcp_rclk_if.sv
// Link between the read check path and its read clock.
// Both ends run on the same clock; no crossing is involved.
`timescale 1ns/1ps
interface trcp_rclk_if;
  logic start; // Request to set the first-bit latch.
  logic check_mode; // High selects the longer read-check cycle.
  logic [3:0] step; // Current read clock step.
  logic adv; // One-cycle pulse in the same cycle as each step change.
  logic idle; // Clock stopped and counter at zero.
  modport ctl (output start, output check_mode, input step, input adv, input idle);
  modport clk (input start, input check_mode, output step, output adv, output idle);
endinterface

// ### logic/trcp_read_clock.sv
// Read clock: microsecond divider, first-bit latch and four-stage step counter.
// Assumes its start request is already synchronised to clk_in.
`timescale 1ns/1ps
`include "trcp_defines.svh"
module trcp_read_clock
  import trcp_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic resetn_in,
  // Link to the read check path.
  trcp_rclk_if.clk rc
);
  trcp_rclk_s s; // Registered state.
  trcp_rclk_s next_s; // Next state.
  logic us_tick; // One cycle per microsecond drive pulse.
  logic [3:0] limit; // Terminal step for this cycle.

  // Next state: the divider only runs while the latch is on, so every byte starts on a full microsecond.
  always_comb
  begin
    next_s = s;
    next_s.adv = 1'b0;
    limit = rc.check_mode ? `TRCP_STEP_END_CHK : `TRCP_STEP_END_RD;
    us_tick = s.first_bit && (s.div == 8'(`TRCP_US_CYC - 1));
    if (!s.first_bit)
    begin
      // Counter and divider stay at zero between bytes.
      next_s.div = 8'h00;
      next_s.step = 4'h0;
      if (rc.start)
      begin
        next_s.first_bit = 1'b1;
      end
    end
    else if (us_tick)
    begin
      next_s.div = 8'h00;
      next_s.adv = 1'b1;
      if (s.step == limit)
      begin
        // Terminal step drops the latch, which clears every stage.
        next_s.first_bit = 1'b0;
        next_s.step = 4'h0;
      end
      else
      begin
        next_s.step = s.step + 4'h1;
      end
    end
    else
    begin
      next_s.div = s.div + 8'h01;
    end
  end

  // State register.
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign rc.step = s.step;
  assign rc.adv = s.adv;
  assign rc.idle = !s.first_bit;

  a_step_bound: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s.step <= `TRCP_STEP_END_CHK) else $error("Read clock step ran past twelve.");
  a_idle_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !s.first_bit |-> s.step == 4'h0) else $error("Counter not zero while stopped.");
endmodule // trcp_read_clock

// ### logic/trcp_top.sv
// Read side of the tape control: byte assembly, longitudinal check, marker recognition.
// Assumes track inputs arrive asynchronously from the read amplifiers; all other inputs
// come from control logic on clk_in. Command inputs are levels held for the operation.
`timescale 1ns/1ps
`include "trcp_defines.svh"
module trcp_top
  import trcp_pkg::*;
#(
  parameter int unsigned GATE_CYC = `TRCP_GATE_CYC // Start delay into data gate, cycles.
)
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic resetn_in,
  // Read amplifier outputs, one per track, parity track at bit 8.
  input wire logic [8:0] track_in,
  // Operation levels.
  input wire logic op_read_in,
  input wire logic op_read_check_in,
  input wire logic op_space_block_in,
  input wire logic op_space_file_in,
  input wire logic op_sense_in,
  input wire logic op_write_in,
  input wire logic seven_track_in,
  // Motion timing pulses.
  input wire logic start_delay_in,
  input wire logic stop_delay_in,
  // Write trigger control.
  input wire logic [8:0] write_data_in,
  input wire logic write_pulse_in,
  input wire logic longitudinal_check_char_write_time_in,
  // Channel side.
  output logic [7:0] channel_byte_register_out,
  output logic channel_parity_out,
  output logic channel_strobe_out,
  output logic sense_strobe_out,
  // Check and status.
  output logic [8:0] track_parity_toggles_out,
  output logic vertical_parity_check_out,
  output logic lrc_error_out,
  output logic data_check_out,
  output logic unit_check_out,
  output logic unit_exception_out,
  output logic space_file_end_out,
  output logic read_disconnect_out,
  output logic file_marker_out,
  output logic data_gate_out,
  // Write triggers.
  output logic [8:0] write_bits_out
);
  trcp_st_s s; // Registered state.
  trcp_st_s next_s; // Next state.
  trcp_rclk_if rc_if (); // Link to the read clock.
  logic reading; // Read forward in progress.
  logic checking; // Read-check of a write in progress.
  logic any_read; // Any operation that reads tape.
  logic ph1; // Step nine, first phase.
  logic ph2; // Step nine, second phase.
  logic xfer; // Step eight set pulse.
  logic tm_rst_win; // Steps two or three of a byte.
  logic mark; // Current byte has marker shape.
  logic rc_was_idle; // Clock idle last cycle, helper for checks.

  // Marker shape decoder, used on the current byte in the assembly latches.
  function automatic logic trcp_is_mark(input logic [8:0] b, input logic seven);
    if (seven)
    begin
      trcp_is_mark = (b & `TRCP_CARE_SEVEN) == `TRCP_MARK_SEVEN;
    end
    else
    begin
      trcp_is_mark = (b & `TRCP_CARE_NINE) == `TRCP_MARK_NINE;
    end
  endfunction

  // Microsecond boundary seen from here: the clock is stopped, so count cycles locally.
  // A separate counter, the same 8-bit width as the read clock divider, times blank space.
  logic [7:0] idle_div; // Free divider for blank-space timing.
  function automatic logic u_rclk_us();
    u_rclk_us = (idle_div == 8'(`TRCP_US_CYC - 1));
  endfunction

  // Read clock instance.
  trcp_read_clock u_rclk (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .rc(rc_if)
  );

  // Step decodes. Phase two of step nine is the cycle after phase one.
  always_comb
  begin
    reading = op_read_in || op_space_block_in || op_space_file_in;
    checking = op_read_check_in;
    any_read = reading || checking;
    xfer = rc_if.adv && (rc_if.step == `TRCP_STEP_XFER);
    ph1 = rc_if.adv && (rc_if.step == `TRCP_STEP_CLR);
    ph2 = s.p2;
    tm_rst_win = (rc_if.step == `TRCP_STEP_TMR_LO) || (rc_if.step == `TRCP_STEP_TMR_HI);
    mark = trcp_is_mark(s.rr, seven_track_in);
    // Any synchronised track bit starts the clock while stopped and gated; sense runs it freely.
    rc_if.start = rc_if.idle && ((s.data_gate && (|s.trk_s2)) || op_sense_in);
    rc_if.check_mode = checking;
  end

  // Next state of the whole path.
  always_comb
  begin
    next_s = s;
    next_s.chan_strobe = 1'b0;
    next_s.sense_strobe = 1'b0;
    next_s.wbits = 9'h000;
    next_s.p2 = ph1;
    // Two flip-flops before the tracks are looked at.
    next_s.trk_s1 = track_in;
    next_s.trk_s2 = s.trk_s1;

    // Data gate: counted from the start delay, dropped at stop delay.
    if (start_delay_in)
    begin
      next_s.gate_run = 1'b1;
      next_s.gate_cnt = 20'h00000;
      next_s.data_gate = 1'b0;
      // A new block clears status and arms first-character logic.
      next_s.first_char = 1'b1;
      next_s.bytes_seen = 1'b0;
      next_s.tm_latch = 1'b0;
      next_s.held = 1'b0;
      next_s.read_disc = 1'b0;
      next_s.eob_us = 8'h00;
      next_s.lrc_err = 1'b0;
      next_s.data_check = 1'b0;
      next_s.unit_check = 1'b0;
      next_s.unit_exc = 1'b0;
      next_s.file_end = 1'b0;
      next_s.rr_vpar_err = 1'b0;
      next_s.toggles = 9'h000;
    end
    else if (stop_delay_in)
    begin
      next_s.gate_run = 1'b0;
      next_s.data_gate = 1'b0;
    end
    else if (s.gate_run && !s.data_gate)
    begin
      if (s.gate_cnt == 20'(GATE_CYC - 1))
      begin
        next_s.data_gate = 1'b1;
      end
      else
      begin
        next_s.gate_cnt = s.gate_cnt + 20'h00001;
      end
    end

    // Byte assembly: ones are caught as they arrive, cleared at step nine.
    if (!s.data_gate || ph1)
    begin
      next_s.rr = 9'h000;
    end
    else
    begin
      next_s.rr = s.rr | s.trk_s2;
    end

    // Check toggles flip on each new one bit in the latches, with no set pulse.
    if (any_read && !start_delay_in)
    begin
      next_s.toggles = s.toggles ^ (next_s.rr & ~s.rr);
    end

    // Step eight: read moves the byte toward the channel; read-check checks parity only.
    if (xfer && op_read_in && !op_write_in)
    begin
      next_s.chan_byte = s.rr[7:0];
      next_s.chan_par = s.rr[8];
      if (s.first_char && mark)
      begin
        // A suspect first byte waits until the block proves to be data.
        next_s.held = 1'b1;
      end
      else if (!s.tm_latch)
      begin
        next_s.chan_strobe = 1'b1;
      end
    end
    if (xfer && checking)
    begin
      // Odd parity expected across all nine tracks.
      next_s.rr_vpar_err = s.rr_vpar_err || !(^s.rr);
    end

    // Marker sample at step nine phase one on the first byte of a forward block.
    if (ph1 && reading && s.first_char)
    begin
      next_s.bytes_seen = 1'b1;
      if (mark)
      begin
        next_s.tm_latch = 1'b1;
      end
    end
    if (ph2 && reading)
    begin
      next_s.first_char = 1'b0;
    end

    // A second byte one space later proves data; disconnect freezes the latch.
    if (s.tm_latch && !s.read_disc && !s.first_char && !rc_if.idle && tm_rst_win)
    begin
      next_s.tm_latch = 1'b0;
      if (s.held)
      begin
        next_s.held = 1'b0;
        next_s.chan_strobe = 1'b1;
      end
    end

    // Blank-space counter: microseconds since the clock last stopped.
    if (!rc_if.idle)
    begin
      next_s.eob_us = 8'h00;
    end
    else if (u_rclk_us() && s.eob_us != 8'hff)
    begin
      next_s.eob_us = s.eob_us + 8'h01;
    end

    // Blank space after a marker-shaped first byte: it is a marker block.
    if (s.tm_latch && !s.read_disc && reading && (s.eob_us == 8'(`TRCP_EOB_MARK_US)))
    begin
      next_s.read_disc = 1'b1;
      next_s.held = 1'b0;
      if (op_space_file_in)
      begin
        next_s.file_end = 1'b1;
      end
      else
      begin
        next_s.unit_exc = 1'b1;
      end
    end

    // End of block: disconnect samples the check toggles.
    if (stop_delay_in && any_read)
    begin
      next_s.read_disc = 1'b1;
      if (|s.toggles)
      begin
        next_s.lrc_err = 1'b1;
        next_s.data_check = 1'b1;
        next_s.unit_check = 1'b1;
      end
    end

    // Sense bytes are spaced by the terminal step of the read clock.
    if (op_sense_in && rc_if.adv && rc_if.step == 4'h0)
    begin
      next_s.sense_strobe = 1'b1;
    end

    // Write triggers: flipped by data, those still on write the check character.
    if (!op_write_in)
    begin
      next_s.wtrig = 9'h000;
    end
    else if (longitudinal_check_char_write_time_in)
    begin
      next_s.wbits = s.wtrig;
      next_s.wtrig = 9'h000;
    end
    else if (write_pulse_in)
    begin
      next_s.wtrig = s.wtrig ^ write_data_in;
    end
  end

  // Blank-space divider register.
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || !rc_if.idle)
    begin
      idle_div <= 8'h00;
    end
    else if (u_rclk_us())
    begin
      idle_div <= 8'h00;
    end
    else
    begin
      idle_div <= idle_div + 8'h01;
    end
  end

  // State register.
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      s <= '0;
      rc_was_idle <= 1'b1;
    end
    else
    begin
      s <= next_s;
      rc_was_idle <= rc_if.idle;
    end
  end

  // Outputs, all taken from the state register.
  assign channel_byte_register_out = s.chan_byte;
  assign channel_parity_out = s.chan_par;
  assign channel_strobe_out = s.chan_strobe;
  assign sense_strobe_out = s.sense_strobe;
  assign track_parity_toggles_out = s.toggles;
  assign vertical_parity_check_out = s.rr_vpar_err;
  assign lrc_error_out = s.lrc_err;
  assign data_check_out = s.data_check;
  assign unit_check_out = s.unit_check;
  assign unit_exception_out = s.unit_exc;
  assign space_file_end_out = s.file_end;
  assign read_disconnect_out = s.read_disc;
  assign file_marker_out = s.tm_latch;
  assign data_gate_out = s.data_gate;
  assign write_bits_out = s.wbits;

  a_gate_clears_rr: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !s.data_gate |=> s.rr == 9'h000) else $error("Latches not cleared without gate.");
  a_step9_clears: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ph1 |=> s.rr == 9'h000) else $error("Latches not cleared at step nine.");
  a_no_start_ungated: assert property (@(posedge clk_in) disable iff (!resetn_in)
    rc_was_idle && !rc_if.idle && !op_sense_in |-> $past(s.data_gate)) else $error("Clock started ungated.");
  a_lrc_sets_checks: assert property (@(posedge clk_in) disable iff (!resetn_in)
    stop_delay_in && any_read && !start_delay_in && (|s.toggles) |=> s.lrc_err && s.data_check && s.unit_check)
    else $error("Toggle left on did not flag errors.");
  a_no_xfer_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
    op_write_in |=> !s.chan_strobe) else $error("Byte sent during write.");
  a_marker_blocks: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s.tm_latch && s.read_disc |-> !s.chan_strobe) else $error("Service given for a marker.");
  a_file_no_exc: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(s.file_end) |-> !s.unit_exc) else $error("File spacing raised exception.");
  a_wbits_trig: assert property (@(posedge clk_in) disable iff (!resetn_in)
    op_write_in && longitudinal_check_char_write_time_in && !start_delay_in |=> s.wbits == $past(s.wtrig) && s.wtrig == 9'h000)
    else $error("Check character bits wrong.");
  a_mark_decode: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ph1 && reading && s.first_char && !start_delay_in && mark |=> s.tm_latch)
    else $error("Marker shape not latched.");
  a_first_char_clr: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ph2 && reading && !start_delay_in |=> !s.first_char) else $error("First-character latch held.");
endmodule // trcp_top

// ### bench/trcp_tape_model.sv
// Tape unit read amplifier model: plays one byte onto the nine track lines with skew.
// Assumes requests arrive on clk_in; an amplifier output rests at 0 between flux pulses.
`timescale 1ns/1ps
module trcp_tape_model
(
  // Clock.
  input wire logic clk_in,
  // Byte request from the bench.
  input wire logic send_in,
  input wire logic [8:0] byte_in,
  // Amplifier outputs, parity track at bit 8.
  output logic [8:0] track_out
);
  // High tracks lag the low ones, so a byte with bits in both groups never arrives whole on its first bit.
  localparam int SKEW = 20;
  localparam int WIDTH = 40; // Length of one flux pulse in cycles.
  logic [8:0] cur; // Byte being played.
  int cnt; // Cycles since the request.
  initial
  begin
    cnt = 1000;
    cur = 9'h000;
  end
  // Start a new byte on request; otherwise let time run on.
  always @(posedge clk_in)
  begin
    if (send_in)
    begin
      cur <= byte_in;
      cnt <= 0;
    end
    else if (cnt < 1000)
    begin
      cnt <= cnt + 1;
    end
  end
  // Lines drop back to rest once each pulse is over.
  always_comb
  begin
    track_out = (cnt < WIDTH) ? (cur & 9'h00f) : 9'h000;
    if (cnt >= SKEW && cnt < SKEW + WIDTH)
    begin
      track_out = track_out | (cur & 9'h1f0);
    end
  end
endmodule // trcp_tape_model

// ### bench/tape_read_check_path_tb.sv
// Self-checking bench for the tape read and check path.
// Assumes the tape model feeds the track lines; a short data gate delay keeps runs brief.
`timescale 1ns/1ps
module tape_read_check_path_tb;
  import trcp_pkg::*;
  localparam int GATE = 100; // Shortened start delay, cycles.
  localparam int SPACE = 3200; // One character space of 16 us.
  localparam int LIMIT = 95000; // Run ceiling in cycles.
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [8:0] track_in;
  logic op_read_in = 0, op_read_check_in = 0, op_space_block_in = 0, op_space_file_in = 0;
  logic op_sense_in = 0, op_write_in = 0, seven_track_in = 0;
  logic start_delay_in = 0, stop_delay_in = 0, write_pulse_in = 0, longitudinal_check_char_write_time_in = 0;
  logic [8:0] write_data_in = 9'h000;
  logic send = 1'b0; // Byte request to the tape model.
  logic [8:0] sbyte = 9'h000; // Byte handed to the tape model.
  logic [7:0] ch_byte;
  logic ch_par, ch_stb, sns_stb, vpc, lrc_err, dchk, uchk, uexc, fend, rdisc, fmark, dgate;
  logic [8:0] toggles, wbits;
  int n_errors = 0, num_checks = 0, cyc = 0, t_send = 0, t_stb = 0, t_sns0 = 0, t_sns1 = 0, n_sns = 0;
  logic [8:0] got[$]; // Parity and byte of every channel transfer.
  always #2.5 clk_in = ~clk_in;
  trcp_tape_model tape (.clk_in(clk_in), .send_in(send), .byte_in(sbyte), .track_out(track_in));
  trcp_top #(.GATE_CYC(GATE)) dut (.clk_in(clk_in), .resetn_in(resetn_in), .track_in(track_in),
    .op_read_in(op_read_in), .op_read_check_in(op_read_check_in), .op_space_block_in(op_space_block_in),
    .op_space_file_in(op_space_file_in), .op_sense_in(op_sense_in), .op_write_in(op_write_in),
    .seven_track_in(seven_track_in), .start_delay_in(start_delay_in), .stop_delay_in(stop_delay_in),
    .write_data_in(write_data_in), .write_pulse_in(write_pulse_in), .longitudinal_check_char_write_time_in(longitudinal_check_char_write_time_in),
    .channel_byte_register_out(ch_byte), .channel_parity_out(ch_par), .channel_strobe_out(ch_stb),
    .sense_strobe_out(sns_stb), .track_parity_toggles_out(toggles), .vertical_parity_check_out(vpc),
    .lrc_error_out(lrc_err), .data_check_out(dchk), .unit_check_out(uchk), .unit_exception_out(uexc),
    .space_file_end_out(fend), .read_disconnect_out(rdisc), .file_marker_out(fmark),
    .data_gate_out(dgate), .write_bits_out(wbits));
  // Monitor: counts cycles, records transfers and sense pacing, cuts a hang short.
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (ch_stb === 1'b1)
    begin
      got.push_back({ch_par, ch_byte});
      t_stb <= cyc;
    end
    if (sns_stb === 1'b1)
    begin
      t_sns0 <= t_sns1;
      t_sns1 <= cyc;
      n_sns <= n_sns + 1;
    end
    if (cyc > LIMIT)
    begin
      n_errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Compare one value with its expectation.
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Reset for eight cycles with every operation level dropped.
  task automatic do_reset();
    @(posedge clk_in);
    resetn_in <= 1'b0;
    {op_read_in, op_read_check_in, op_space_block_in, op_space_file_in} <= 4'h0;
    {op_sense_in, op_write_in, seven_track_in} <= 3'h0;
    tick(8);
    resetn_in <= 1'b1;
    got.delete();
    tick(2);
  endtask
  // Start delay pulse, then wait for the data gate.
  task automatic begin_block();
    @(posedge clk_in);
    start_delay_in <= 1'b1;
    @(posedge clk_in);
    start_delay_in <= 1'b0;
    tick(GATE + 8);
  endtask
  // Play one byte and wait out one character space.
  task automatic send_byte(input logic [8:0] b);
    @(posedge clk_in);
    send <= 1'b1;
    sbyte <= b;
    t_send = cyc;
    @(posedge clk_in);
    send <= 1'b0;
    tick(SPACE - 2);
  endtask
  task automatic pulse_stop();
    @(posedge clk_in);
    stop_delay_in <= 1'b1;
    @(posedge clk_in);
    stop_delay_in <= 1'b0;
    tick(3);
  endtask
  // One row per marker case: seven-track, read, space block, space file, exception, file end.
  logic [5:0] mrow[4] = '{6'b010010, 6'b001010, 6'b000101, 6'b110010};
  initial
  begin
    tick(8);
    resetn_in <= 1'b1;
    tick(2);
    check({lrc_err, dchk, uchk, uexc, fend, rdisc, fmark, dgate, ch_stb}, 9'h000);
    // Data block whose check character leaves every track even.
    op_read_in <= 1'b1;
    send_byte(9'h1a5);
    check(toggles, 9'h000);
    check(9'(got.size()), 9'h000);
    @(posedge clk_in);
    start_delay_in <= 1'b1;
    @(posedge clk_in);
    start_delay_in <= 1'b0;
    tick(GATE - 5);
    check(dgate, 9'h000);
    tick(12);
    check(dgate, 9'h001);
    send_byte(9'h1a5);
    check(9'((t_stb - t_send) > 8 * 200 && (t_stb - t_send) < 9 * 200), 9'h001);
    send_byte(9'h032);
    check(toggles, 9'h197);
    send_byte(9'h197);
    check(toggles, 9'h000);
    check(got[0], 9'h1a5);
    check(got[1], 9'h032);
    pulse_stop();
    check({rdisc, lrc_err, dchk, uchk}, 9'h008);
    check(dgate, 9'h000);
    // Block left with odd tracks raises the longitudinal error chain.
    do_reset();
    op_read_in <= 1'b1;
    begin_block();
    send_byte(9'h1a5);
    pulse_stop();
    check({rdisc, lrc_err, dchk, uchk}, 9'h00f);
    // Lone marker characters under read, space block and space file.
    for (int i = 0; i < 4; i++)
    begin
      do_reset();
      seven_track_in <= mrow[i][5];
      op_read_in <= mrow[i][4];
      op_space_block_in <= mrow[i][3];
      op_space_file_in <= mrow[i][2];
      begin_block();
      send_byte(mrow[i][5] ? 9'h00f : 9'h0c8);
      tick(7000);
      check({fmark, rdisc, uexc, fend}, {7'h03, mrow[i][1:0]});
      check(9'(got.size()), 9'h000);
    end
    // Marker-shaped first byte followed one space later by data.
    do_reset();
    op_read_in <= 1'b1;
    begin_block();
    send_byte(9'h0c8);
    check(fmark, 9'h001);
    check(9'(got.size()), 9'h000);
    send_byte(9'h101);
    check(fmark, 9'h000);
    check(9'(got.size()), 9'h002);
    check(got[0], 9'h0c8);
    check(got[1], 9'h101);
    check(rdisc, 9'h000);
    // Read check during a write: parity checked, nothing to the channel.
    do_reset();
    op_write_in <= 1'b1;
    op_read_check_in <= 1'b1;
    begin_block();
    send_byte(9'h007);
    check(vpc, 9'h000);
    send_byte(9'h003);
    check(vpc, 9'h001);
    check(toggles, 9'h004);
    check(9'(got.size()), 9'h000);
    // Longitudinal check character from the write triggers.
    do_reset();
    op_write_in <= 1'b1;
    write_data_in <= 9'h055;
    write_pulse_in <= 1'b1;
    @(posedge clk_in);
    write_pulse_in <= 1'b0;
    @(posedge clk_in);
    write_data_in <= 9'h011;
    write_pulse_in <= 1'b1;
    @(posedge clk_in);
    write_pulse_in <= 1'b0;
    tick(2);
    longitudinal_check_char_write_time_in <= 1'b1;
    @(posedge clk_in);
    longitudinal_check_char_write_time_in <= 1'b0;
    #1;
    check(wbits, 9'h044);
    @(posedge clk_in);
    #1;
    check(wbits, 9'h000);
    // Sense bytes paced by the free-running read clock.
    do_reset();
    op_sense_in <= 1'b1;
    tick(8000);
    check(9'(n_sns > 2), 9'h001);
    check(9'((t_sns1 - t_sns0) >= 10 * 200 && (t_sns1 - t_sns0) <= 14 * 200), 9'h001);
    end_sim();
  end
endmodule // tape_read_check_path_tb
